// ### include/dsl_pkg.sv
// ****************************************************************
// Constants and carriers of the decoder status pin logic.
// ****************************************************************
package dsl_pkg;

    // ************************************************************
    // Register map, byte addresses on the APB bus.
    // ************************************************************
    localparam logic [11:0] PIN_STATUS_ADDR = 12'h0_0c8;
    localparam logic [11:0] CONTROL_ADDR = 12'h0_0cc;
    localparam logic [11:0] FLAG_STATUS_ADDR = 12'h0_0d0;
    localparam int PIN_STATUS_WIDTH = 20;

    // Control register fields and reset value.
    localparam int CTRL_THRESH_LSB = 0;
    localparam int CTRL_THRESH_W = 8;
    localparam int CTRL_SWAP_BIT = 8;
    localparam logic [31:0] CONTROL_RESET = 32'h0000_0080;

    // Flag status register bit positions.
    localparam int FLAG_HDR_READY = 0;
    localparam int FLAG_AUDIO_LOCK = 1;
    localparam int FLAG_BC_LOCK = 2;
    localparam int FLAG_FAULT = 3;
    localparam int FLAG_CLOCK_OK = 4;
    localparam int FLAG_SUPPLY_OK = 5;
    localparam int FLAG_ALT_SEL = 6;
    localparam int FLAG_TOGGLE = 7;

    // Positions of the parallel pins inside the pin status word.
    localparam int PIN_JACK = 3;

    // Events and levels reported by the decoder core.
    typedef struct packed {
        logic bcFrameOk;
        logic schDecoded;
        logic bcDecoding;
        logic decodeErr;
        logic noInput;
        logic mpegHeaderOk;
        logic clockValid;
        logic synthLocked;
        logic sampleRight;
        logic serialOutClk;
        logic serialOutData;
    } dsl_core_s;

    // Host read commands recognised by the control interface.
    typedef struct packed {
        logic schRead;
        logic ancRead;
    } dsl_cmd_s;

    // Input pins that arrive from outside the clock domain.
    typedef struct packed {
        logic altInputSelect;
        logic jackSense;
        logic primaryClk;
        logic primaryFrame;
        logic primaryData;
        logic altClk;
        logic altFrame;
        logic altData;
        logic dspEnable;
        logic converterEnable;
        logic [3:0] reserved;
    } dsl_pin_s;

    // Selected broadcast input lines.
    typedef struct packed {
        logic clk;
        logic frame;
        logic data;
    } dsl_serial_s;

endpackage

// ### verilog/dsl_status_pins.sv
// Functional notes
// - Frame toggle output inverts on every correctly decoded broadcast frame.
// - Low input select pin takes bitstream from alternative lines, ignores primary.
// - Header ready is 0 after reset and set on each decoded header.
// - Only a host header read clears header ready.
// - Broadcast sync output is high while the bitstream decodes correctly.
// - Decode fault is high on decoding errors or missing input stream.
// - Audio sync is low after reset, set on valid Layer 3 header.
// - Audio sync clears when the host reads ancillary data.
// - Parallel pin levels are readable in the status word at c8.
// - Jack sense level appears in bit 3 of the status word.
// - With DSP disabled, ready output shows a valid reference clock.
// - With DSP enabled, ready output stays 0 until synthesizer locks.
// - Channel select is low for left samples, high for right by default.
// - Audio clock output follows the locked synthesizer clock.
// - Reset clears all digital logic except the control register, which loads 0x80.
// - Supply good output is high above a software set threshold.
// - Alternative data line feeds broadcast data when alternatives are selected.
// - Converter runs while the converter enable input is asserted.
// - Header read command clears header ready before the first data word.
`timescale 1ns/1ps
module dsl_status_pins
(
    input wire logic clock,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire dsl_pkg::dsl_core_s coreIn,
    input wire dsl_pkg::dsl_cmd_s hostCmd,
    input wire dsl_pkg::dsl_pin_s pinIn,
    input wire logic [7:0] supplyLevel,
    input wire logic synthClock,
    output logic frameToggleOut,
    output logic headerReadyOut,
    output logic broadcastLockedOut,
    output logic decodeFaultOut,
    output logic audioHeaderLockedOut,
    output logic clockOkOut,
    output logic supplyGoodOut,
    output logic outChannelSelect,
    output logic audioClockOut,
    output logic converterRun,
    output dsl_pkg::dsl_serial_s bcSerial
);

    // ************************************************************
    // Pin synchronisers.
    // ************************************************************
    dsl_pkg::dsl_pin_s pinMeta_r;
    dsl_pkg::dsl_pin_s pinSync_r;

    // Two flip-flops before any logic looks at a pin.
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            pinMeta_r <= '0;
            pinSync_r <= '0;
        end
        else
        begin
            pinMeta_r <= pinIn;
            pinSync_r <= pinMeta_r;
        end
    end

    // ************************************************************
    // Register bus decode.
    // ************************************************************
    logic [31:0] control_r;
    logic [31:0] prdata_r;
    logic [31:0] readMux;
    logic [31:0] flagWord;
    logic [31:0] pinWord;
    logic hitPins;
    logic hitCtrl;
    logic hitFlags;
    logic mapped;
    logic setupRead;
    logic ctrlWrite;

    // Address decode and qualified strobes.
    assign hitPins = (paddr == dsl_pkg::PIN_STATUS_ADDR);
    assign hitCtrl = (paddr == dsl_pkg::CONTROL_ADDR);
    assign hitFlags = (paddr == dsl_pkg::FLAG_STATUS_ADDR);
    assign mapped = hitPins | hitCtrl | hitFlags;
    assign setupRead = psel & ~penable & ~pwrite;
    assign ctrlWrite = psel & penable & pwrite & hitCtrl;
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~mapped;
    assign prdata = prdata_r;

    // Read data selection; unmapped addresses read zero.
    assign readMux = hitPins ? pinWord :
                     hitCtrl ? control_r :
                     hitFlags ? flagWord : 32'h0000_0000;

    // Read data is captured in the setup cycle and held through access.
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            prdata_r <= 32'h0000_0000;
        end
        else if (setupRead)
        begin
            prdata_r <= readMux;
        end
    end

    // Control register write.
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            control_r <= dsl_pkg::CONTROL_RESET;
        end
        else if (ctrlWrite)
        begin
            control_r <= {23'h00_0000, pwdata[8:0]};
        end
    end

    // ************************************************************
    // Broadcast and audio status flags.
    // ************************************************************
    logic toggle_r;
    logic toggle_nxt;
    logic hdrReady_r;
    logic hdrReady_nxt;
    logic audioLock_r;
    logic audioLock_nxt;
    logic bcLock_r;
    logic fault_r;

    assign toggle_nxt = toggle_r ^ coreIn.bcFrameOk;
    // header ready set; host read clears, set wins
    // clear on read command before data
    assign hdrReady_nxt = coreIn.schDecoded | (hdrReady_r & ~hostCmd.schRead);
    // audio sync set; ancillary read clears
    assign audioLock_nxt = coreIn.mpegHeaderOk | (audioLock_r & ~hostCmd.ancRead);

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            toggle_r <= 1'b0;
            hdrReady_r <= 1'b0;
            audioLock_r <= 1'b0;
            bcLock_r <= 1'b0;
            fault_r <= 1'b0;
        end
        else
        begin
            toggle_r <= toggle_nxt;
            hdrReady_r <= hdrReady_nxt;
            audioLock_r <= audioLock_nxt;
            bcLock_r <= coreIn.bcDecoding;
            // fault on error or no input
            fault_r <= coreIn.decodeErr | coreIn.noInput;
        end
    end

    assign frameToggleOut = toggle_r;
    assign headerReadyOut = hdrReady_r;
    assign audioHeaderLockedOut = audioLock_r;
    assign broadcastLockedOut = bcLock_r;
    assign decodeFaultOut = fault_r;

    // ************************************************************
    // Clock, supply and converter status.
    // ************************************************************
    logic clockOk_r;
    logic supplyOk_r;
    logic convRun_r;
    logic chanSel_r;
    logic clockOkNxt;
    logic supplyOkNxt;
    logic [7:0] threshold;

    assign clockOkNxt = pinSync_r.dspEnable ? coreIn.synthLocked : coreIn.clockValid;
    assign threshold = control_r[dsl_pkg::CTRL_THRESH_LSB +: dsl_pkg::CTRL_THRESH_W];
    assign supplyOkNxt = (supplyLevel > threshold);

    // Status outputs come from flip-flops.
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            clockOk_r <= 1'b0;
            supplyOk_r <= 1'b0;
            convRun_r <= 1'b0;
            chanSel_r <= 1'b0;
        end
        else
        begin
            clockOk_r <= clockOkNxt;
            supplyOk_r <= supplyOkNxt;
            convRun_r <= pinSync_r.converterEnable;
            // low left, high right unless swapped
            chanSel_r <= coreIn.sampleRight ^ control_r[dsl_pkg::CTRL_SWAP_BIT];
        end
    end

    assign clockOkOut = clockOk_r;
    assign supplyGoodOut = supplyOk_r;
    assign converterRun = convRun_r;
    assign outChannelSelect = chanSel_r;
    // audio clock passes only while the synthesizer is locked
    assign audioClockOut = synthClock & clockOk_r & pinSync_r.dspEnable;

    // ************************************************************
    // Broadcast input selection.
    // ************************************************************
    dsl_pkg::dsl_serial_s serial_r;
    dsl_pkg::dsl_serial_s serialNxt;

    // low select takes alternatives; alternative data line
    assign serialNxt = pinSync_r.altInputSelect ?
        {pinSync_r.primaryClk, pinSync_r.primaryFrame, pinSync_r.primaryData} :
        {pinSync_r.altClk, pinSync_r.altFrame, pinSync_r.altData};

    // Selected lines registered before leaving the block.
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            serial_r <= '0;
        end
        else
        begin
            serial_r <= serialNxt;
        end
    end

    assign bcSerial = serial_r;

    // ************************************************************
    // Status words.
    // ************************************************************
    // pin levels readable, mixed with status flags; bit order differs from dsl_pin_s
    // jack sense lands in bit 3
    assign pinWord = {12'h000,
                      toggle_r, pinSync_r.altInputSelect, pinSync_r.reserved[3],
                      pinSync_r.altClk, pinSync_r.altFrame, pinSync_r.altData,
                      hdrReady_r, bcLock_r, coreIn.serialOutData, chanSel_r,
                      coreIn.serialOutClk, fault_r,
                      pinSync_r.primaryData, pinSync_r.primaryFrame, pinSync_r.primaryClk,
                      audioLock_r, pinSync_r.jackSense, pinSync_r.reserved[2:0]};

    // Flag word collects the block's own state.
    assign flagWord = {24'h00_0000, toggle_r, pinSync_r.altInputSelect, supplyOk_r,
                       clockOk_r, fault_r, bcLock_r, audioLock_r, hdrReady_r};

    // ************************************************************
    // Assertions.
    // ************************************************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    sequence hdrSet;
        coreIn.schDecoded;
    endsequence

    sequence hdrReadNoSet;
        hostCmd.schRead && !coreIn.schDecoded;
    endsequence

    sequence refClockMode;
        !pinSync_r.dspEnable && coreIn.clockValid;
    endsequence

    sequence dspLockedMode;
        pinSync_r.dspEnable && coreIn.synthLocked;
    endsequence

    a_toggle_on_frame: assert property (
        coreIn.bcFrameOk |=> (frameToggleOut != $past(frameToggleOut)))
        else $error("Frame toggle did not invert.");

    a_toggle_hold: assert property (
        !coreIn.bcFrameOk |=> $stable(frameToggleOut))
        else $error("Frame toggle changed without a frame.");

    a_hdr_set: assert property (
        hdrSet |=> headerReadyOut)
        else $error("Header ready not set after header decode.");

    a_hdr_only_read: assert property (
        headerReadyOut && !hostCmd.schRead |=> headerReadyOut)
        else $error("Header ready cleared without a host read.");

    a_hdr_read_clear: assert property (
        hdrReadNoSet |=> !headerReadyOut)
        else $error("Header ready not cleared by the read command.");

    a_audio_clear: assert property (
        hostCmd.ancRead && !coreIn.mpegHeaderOk |=> !audioHeaderLockedOut)
        else $error("Audio sync not cleared by ancillary read.");

    a_audio_set: assert property (
        coreIn.mpegHeaderOk |=> audioHeaderLockedOut)
        else $error("Audio sync not set after header.");

    a_fault_flag: assert property (
        (coreIn.decodeErr || coreIn.noInput) |=> decodeFaultOut)
        else $error("Decode fault not raised.");

    a_ready_locked: assert property (
        pinSync_r.dspEnable && !coreIn.synthLocked |=> !clockOkOut)
        else $error("Ready high before synthesizer lock.");

    a_alt_select: assert property (
        !pinSync_r.altInputSelect |=> (bcSerial.data == $past(pinSync_r.altData)))
        else $error("Alternative data line not selected.");

    a_jack_bit: assert property (
        pinWord[dsl_pkg::PIN_JACK] == pinSync_r.jackSense)
        else $error("Jack sense not in status bit 3.");

    a_bc_lock_set: assert property (
        coreIn.bcDecoding |=> broadcastLockedOut)
        else $error("Broadcast sync not raised while decoding.");

    a_bc_lock_clear: assert property (
        !coreIn.bcDecoding |=> !broadcastLockedOut)
        else $error("Broadcast sync held without decoding.");

    a_fault_clear: assert property (
        !(coreIn.decodeErr || coreIn.noInput) |=> !decodeFaultOut)
        else $error("Decode fault raised without a cause.");

    a_ready_ref: assert property (
        refClockMode |=> clockOkOut)
        else $error("Ready low although the reference clock is valid.");

    a_ready_ref_low: assert property (
        !pinSync_r.dspEnable && !coreIn.clockValid |=> !clockOkOut)
        else $error("Ready high without a valid reference clock.");

    a_ready_lock_high: assert property (
        dspLockedMode |=> clockOkOut)
        else $error("Ready low after synthesizer lock.");

    a_conv_follow: assert property (
        converterRun == $past(pinSync_r.converterEnable))
        else $error("Converter run does not follow its enable.");

    a_chan_sel: assert property (
        !control_r[dsl_pkg::CTRL_SWAP_BIT] |=> (outChannelSelect == $past(coreIn.sampleRight)))
        else $error("Channel select does not follow the sample side.");

    a_primary_select: assert property (
        pinSync_r.altInputSelect |=> (bcSerial.data == $past(pinSync_r.primaryData)))
        else $error("Primary data line not selected.");

    a_supply_good: assert property (
        (supplyLevel > threshold) |=> supplyGoodOut)
        else $error("Supply good low above the threshold.");

    a_supply_low: assert property (
        (supplyLevel <= threshold) |=> !supplyGoodOut)
        else $error("Supply good high at or below the threshold.");

    a_audio_gate: assert property (
        !clockOkOut |-> !audioClockOut)
        else $error("Audio clock passes before lock.");

endmodule // dsl_status_pins

// ### verif/dsl_host_model.sv
`timescale 1ns/1ps
// ****************************************************************
// Host microcontroller model: read commands and DSP enable.
// ****************************************************************
module dsl_host_model
(
    input wire logic clock,
    output dsl_pkg::dsl_cmd_s hostCmd,
    output logic dspEnable
);
    // The host starts idle with the DSP switched off.
    initial
    begin
        hostCmd = '0;
        dspEnable = 1'b0;
    end

    task readSch();
        @(posedge clock);
        hostCmd.schRead <= 1'b1;
        @(posedge clock);
        hostCmd.schRead <= 1'b0;
    endtask

    task readAnc();
        @(posedge clock);
        hostCmd.ancRead <= 1'b1;
        @(posedge clock);
        hostCmd.ancRead <= 1'b0;
    endtask

    task setDsp(input logic v);
        @(posedge clock);
        dspEnable <= v;
    endtask
endmodule // dsl_host_model

// ### verif/tb.sv
`timescale 1ns/1ps
// ****************************************************************
// Self-checking bench for the status pin logic.
// ****************************************************************
module tb;
    logic clock, rst, psel, penable, pwrite, pready, pslverr, err, dspEnable, synthClock;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [7:0] supplyLevel;
    dsl_pkg::dsl_core_s coreIn;
    dsl_pkg::dsl_cmd_s hostCmd;
    dsl_pkg::dsl_pin_s pinDrv, pinIn;
    dsl_pkg::dsl_serial_s bcSerial;
    logic frameToggleOut, headerReadyOut, broadcastLockedOut, decodeFaultOut, audioHeaderLockedOut;
    logic clockOkOut, supplyGoodOut, outChannelSelect, audioClockOut, converterRun;
    int errors;
    int tests_run;

    dsl_status_pins uut (.clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .coreIn(coreIn), .hostCmd(hostCmd), .pinIn(pinIn), .supplyLevel(supplyLevel),
        .synthClock(synthClock), .frameToggleOut(frameToggleOut), .headerReadyOut(headerReadyOut),
        .broadcastLockedOut(broadcastLockedOut), .decodeFaultOut(decodeFaultOut),
        .audioHeaderLockedOut(audioHeaderLockedOut), .clockOkOut(clockOkOut),
        .supplyGoodOut(supplyGoodOut), .outChannelSelect(outChannelSelect),
        .audioClockOut(audioClockOut), .converterRun(converterRun), .bcSerial(bcSerial));
    dsl_host_model host (.clock(clock), .hostCmd(hostCmd), .dspEnable(dspEnable));

    // The DSP enable pin comes from the host model, the rest from the bench.
    always_comb
    begin
        pinIn = pinDrv;
        pinIn.dspEnable = dspEnable;
    end

    // Clock of 40 ns period.
    always #20 clock = ~clock;

    // ************************************************************
    // Shared helpers.
    // ************************************************************
    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Waits n rising edges, then samples at the following falling edge.
    task settle(input int n);
        repeat (n) @(posedge clock);
        @(negedge clock);
    endtask

    // One APB transfer; waits for pready under the watchdog.
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task summarize();
        if (errors == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // ************************************************************
    // Scenarios.
    // ************************************************************
    task t_reset();
        @(negedge clock);
        chk(headerReadyOut, 0); // header flag clear.
        chk(audioHeaderLockedOut, 0); // audio sync clear.
        chk(frameToggleOut, 0); // toggle cleared.
        apb(1'b0, dsl_pkg::CONTROL_ADDR, '0);
        chk(rd, dsl_pkg::CONTROL_RESET); // control reset value.
    endtask

    // Two back-to-back good frames invert the toggle twice.
    task t_toggle();
        @(posedge clock);
        coreIn.bcFrameOk <= 1'b1;
        settle(1);
        chk(frameToggleOut, 1); // first inversion.
        @(posedge clock);
        coreIn.bcFrameOk <= 1'b0;
        @(negedge clock);
        chk(frameToggleOut, 0); // second inversion.
        settle(2);
        chk(frameToggleOut, 0); // no frame, no change.
    endtask

    task t_header();
        @(posedge clock);
        coreIn.schDecoded <= 1'b1;
        @(posedge clock);
        coreIn.schDecoded <= 1'b0;
        @(negedge clock);
        chk(headerReadyOut, 1); // set on header.
        host.readAnc();
        settle(2);
        chk(headerReadyOut, 1); // other reads keep it.
        host.readSch();
        @(negedge clock);
        chk(headerReadyOut, 0); // cleared by header read.
    endtask

    task t_audio();
        @(posedge clock);
        coreIn.mpegHeaderOk <= 1'b1;
        @(posedge clock);
        coreIn.mpegHeaderOk <= 1'b0;
        @(negedge clock);
        chk(audioHeaderLockedOut, 1); // set on valid header.
        host.readSch();
        settle(2);
        chk(audioHeaderLockedOut, 1); // header read keeps it.
        host.readAnc();
        @(negedge clock);
        chk(audioHeaderLockedOut, 0); // ancillary read clears.
    endtask

    task t_levels();
        @(posedge clock);
        coreIn.bcDecoding <= 1'b1;
        settle(1);
        chk(broadcastLockedOut, 1); // locked while decoding.
        @(posedge clock);
        coreIn.bcDecoding <= 1'b0;
        coreIn.decodeErr <= 1'b1;
        settle(1);
        chk(broadcastLockedOut, 0); // drops when not decoding.
        chk(decodeFaultOut, 1); // decoding error.
        @(posedge clock);
        coreIn.decodeErr <= 1'b0;
        coreIn.noInput <= 1'b1;
        settle(1);
        chk(decodeFaultOut, 1); // missing input.
        @(posedge clock);
        coreIn.noInput <= 1'b0;
        settle(1);
        chk(decodeFaultOut, 0); // fault gone.
    endtask

    // Alternative lines carry 1,0,1 and primary lines 0,1,0.
    task t_select();
        @(posedge clock);
        {pinDrv.altClk, pinDrv.altFrame, pinDrv.altData} <= 3'b101;
        {pinDrv.primaryClk, pinDrv.primaryFrame, pinDrv.primaryData} <= 3'b010;
        pinDrv.altInputSelect <= 1'b0;
        settle(3);
        chk(bcSerial, 3'b101); // alternative lines used.
        @(posedge clock);
        pinDrv.altInputSelect <= 1'b1;
        settle(3);
        chk(bcSerial, 3'b010); // primary lines used.
    endtask

    task t_clock();
        @(posedge clock);
        coreIn.clockValid <= 1'b1;
        coreIn.synthLocked <= 1'b0;
        settle(3);
        chk(clockOkOut, 1); // valid reference clock.
        host.setDsp(1'b1);
        settle(3);
        chk(clockOkOut, 0); // low until lock.
        @(posedge clock);
        coreIn.synthLocked <= 1'b1;
        synthClock <= 1'b1;
        @(negedge clock);
        chk(audioClockOut, 0); // no clock before lock.
        settle(1);
        chk(clockOkOut, 1); // high after lock.
        chk(audioClockOut, 1); // clock passes when locked.
        @(posedge clock);
        synthClock <= 1'b0;
        @(negedge clock);
        chk(audioClockOut, 0); // clock follows synthesizer.
    endtask

    task t_regs();
        @(posedge clock);
        pinDrv.jackSense <= 1'b1;
        pinDrv.converterEnable <= 1'b1;
        pinDrv.reserved <= 4'b1010;
        coreIn.sampleRight <= 1'b1;
        settle(3);
        chk(converterRun, 1); // converter runs.
        chk(outChannelSelect, 1); // right sample high.
        apb(1'b0, dsl_pkg::PIN_STATUS_ADDR, '0);
        chk(rd & 32'h0006_000f, 32'h0006_000a); // pin bits.
        apb(1'b0, dsl_pkg::FLAG_STATUS_ADDR, '0);
        chk(rd, 32'h0000_0050); // only clock ok and select flags set.
        @(posedge clock);
        pinDrv.jackSense <= 1'b0;
        coreIn.sampleRight <= 1'b0;
        settle(3);
        chk(outChannelSelect, 0); // left sample low.
        apb(1'b0, dsl_pkg::PIN_STATUS_ADDR, '0);
        chk(rd & 32'h0000_0008, 32'h0000_0000); // jack bit follows pin.
        apb(1'b0, 12'h0_0f0, '0);
        chk(err, 1'b1); // unmapped address refused.
        chk(rd, 32'h0000_0000); // unmapped address reads zero.
        apb(1'b1, dsl_pkg::CONTROL_ADDR, 32'h0000_0010);
        supplyLevel <= 8'h10;
        settle(2);
        chk(supplyGoodOut, 0); // equal level is not good.
        @(posedge clock);
        supplyLevel <= 8'h11;
        settle(2);
        chk(supplyGoodOut, 1); // above threshold.
        apb(1'b1, dsl_pkg::CONTROL_ADDR, 32'hffff_ff10);
        settle(1);
        chk(outChannelSelect, 1); // swapped polarity marks left high.
        apb(1'b0, dsl_pkg::CONTROL_ADDR, '0);
        chk(rd, 32'h0000_0110); // control keeps nine bits.
    endtask

    // A reset in mid-run clears the flags and returns the control register to its reset value.
    task t_rst2();
        @(posedge clock);
        coreIn <= '0;
        @(posedge clock);
        coreIn.schDecoded <= 1'b1;
        @(posedge clock);
        coreIn.schDecoded <= 1'b0;
        @(negedge clock);
        chk(headerReadyOut, 1); // flag set before reset.
        @(posedge clock);
        rst <= 1'b1;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        @(negedge clock);
        chk({headerReadyOut, clockOkOut, converterRun, outChannelSelect}, 4'h0); // outputs cleared.
        apb(1'b0, dsl_pkg::CONTROL_ADDR, '0);
        chk(rd, dsl_pkg::CONTROL_RESET); // control back to reset value.
    endtask

    // Reset and the scenario sequence.
    initial
    begin
        clock = 1'b0;
        rst = 1'b1;
        {psel, penable, pwrite, synthClock} = '0;
        paddr = '0;
        pwdata = '0;
        coreIn = '0;
        pinDrv = '0;
        supplyLevel = '0;
        errors = 0;
        tests_run = 0;
        repeat (20) @(posedge clock);
        rst <= 1'b0;
        t_reset();
        t_toggle();
        t_header();
        t_audio();
        t_levels();
        t_select();
        t_clock();
        t_regs();
        t_rst2();
        summarize();
    end

    // Watchdog against a hung handshake.
    initial
    begin
        repeat (3000) @(posedge clock);
        errors++;
        summarize();
    end
endmodule // tb
